// [pkg/rrx_pkg.sv]
// Package of constants for the remote-control pulse decoder
// Summary of operation
// - Counter clock is fc over 2^6..2^12
// - Polarity bit one inverts the input
// - Source: rising, falling, both, byte received
// - Threshold time is sixteen counts per step
// - Compare counter upper nibble with threshold
// - Run bit zero stops, clears counter
// - Measure mode ignored for both-edge source
// - Receive-end mode raises interrupt per byte
// - Capture register read-only, resets to zero
// - Data buffer read-only, holds decided bits
// - Overflow flag reads one after overflow
// - Next bit monitor shows threshold decision
// - Monitor shows filtered input level
// - Status shows receive bit counter
// - Noise time drops pulses shorter than it
// - Measurement captures, clears, interrupts, keeps counting
// - Overflow interrupts, flags, clears, stops counter
// - Receive-end shifts bits, interrupts after eight
// - Bit counter restarts at one after byte
package rrx_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] RRX_IDX_CTRL_ONE = 12'hFD0;
	localparam logic [11:0] RRX_IDX_CTRL_TWO = 12'hFD1;
	localparam logic [11:0] RRX_IDX_CAPTURE = 12'hFD2;
	localparam logic [11:0] RRX_IDX_BUFFER = 12'hFD3;
	localparam logic [11:0] RRX_IDX_STATUS = 12'hFD4;
	localparam int RRX_ADDR_W = 14;
	// Reset values
	localparam logic [7:0] RRX_CTRL_RESET = 8'h00;
	localparam logic [7:0] RRX_DATA_RESET = 8'h00;
	// Control one fields
	localparam int RRX_CCK_LSB = 6;
	localparam int RRX_POL_BIT = 5;
	localparam int RRX_SRC_LSB = 3;
	localparam int RRX_NOISE_LSB = 0;
	// Control two fields
	localparam int RRX_THR_LSB = 4;
	localparam int RRX_RUN_BIT = 3;
	localparam int RRX_MODE_LSB = 0;
	// Status fields
	localparam int RRX_BCNT_LSB = 4;
	localparam int RRX_OVF_BIT = 2;
	localparam int RRX_NEXT_BIT = 1;
	localparam int RRX_FILT_BIT = 0;
	// Interrupt source codes
	localparam logic [1:0] RRX_SRC_RISE = 2'h0;
	localparam logic [1:0] RRX_SRC_FALL = 2'h1;
	localparam logic [1:0] RRX_SRC_BOTH = 2'h2;
	localparam logic [1:0] RRX_SRC_BYTE = 2'h3;
	// Measure mode codes that gate counting to one level
	localparam logic [1:0] RRX_MODE_HIGH = 2'h2;
	localparam logic [1:0] RRX_MODE_LOW = 2'h3;
	// Prescaler width and counter full value
	localparam int RRX_PRE_W = 12;
	localparam logic [7:0] RRX_CNT_FULL = 8'hFF;
	localparam logic [3:0] RRX_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] RRX_BCNT_FIRST = 4'h1;
	// Noise canceler windows in fc cycles for codes 1 to 5
	localparam int RRX_NOISE_W = 15;
	localparam logic [14:0] RRX_NOISE_1 = 15'h0020;
	localparam logic [14:0] RRX_NOISE_2 = 15'h0100;
	localparam logic [14:0] RRX_NOISE_3 = 15'h0200;
	localparam logic [14:0] RRX_NOISE_4 = 15'h0400;
	localparam logic [14:0] RRX_NOISE_5 = 15'h0800;
endpackage : rrx_pkg

// [verilog/rrx_decoder.sv]
// Remote-control pulse decoder with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
module rrx_decoder #(
	parameter logic [14:0] NOISE_CNT_6 = 15'h2000, // Window for noise code 6, shorten in simulation
	parameter logic [14:0] NOISE_CNT_7 = 15'h4000 // Window for noise code 7, shorten in simulation
) (
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic CLOCK_EN_I,
	input wire logic [rrx_pkg::RRX_ADDR_W-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic REMOTE_SIGNAL_INPUT_I,
	output logic EXT_INTERRUPT_THREE_O
);
	import rrx_pkg::*;

	// Prescaler mask for a code: low bits that must all be one
	function automatic logic [RRX_PRE_W-1:0] pre_mask(input logic [1:0] code);
		case (code)
			2'h0: pre_mask = 12'h03F;
			2'h1: pre_mask = 12'h0FF;
			2'h2: pre_mask = 12'h3FF;
			default: pre_mask = 12'hFFF;
		endcase
	endfunction : pre_mask

	// Noise window in fc cycles; zero means pass through
	function automatic logic [RRX_NOISE_W-1:0] noise_len(input logic [2:0] code);
		case (code)
			3'h1: noise_len = RRX_NOISE_1;
			3'h2: noise_len = RRX_NOISE_2;
			3'h3: noise_len = RRX_NOISE_3;
			3'h4: noise_len = RRX_NOISE_4;
			3'h5: noise_len = RRX_NOISE_5;
			3'h6: noise_len = NOISE_CNT_6;
			3'h7: noise_len = NOISE_CNT_7;
			default: noise_len = '0;
		endcase
	endfunction : noise_len

	// Software registers
	logic [7:0] ctrl_one_reg; // Clock, polarity, source, noise
	logic [7:0] ctrl_two_reg; // Threshold, run, mode
	logic [7:0] capture_reg; // Counter snapshot
	logic [7:0] buffer_reg; // Decided bits
	// Engine state
	logic [RRX_PRE_W-1:0] pre_reg; // Free-running divider
	logic tick_reg; // One-cycle counter clock enable
	logic sync1_reg; // Synchroniser first stage
	logic sync2_reg; // Synchroniser second stage
	logic [RRX_NOISE_W-1:0] noise_cnt_reg; // Disagreement run length
	logic filt_reg; // Filtered, polarity-corrected level
	logic filt_prev_reg; // Last filtered level for edges
	logic [7:0] count_reg; // Measurement up-counter
	logic ovf_reg; // Overflow flag, also halts counting
	logic [3:0] bcnt_reg; // Receive bit counter
	logic byte_done_reg; // Byte finished, next edge restarts count
	logic irq_reg; // Interrupt pulse
	logic next_bit_reg; // Registered threshold decision
	// Bus state
	logic wait_reg; // Waitrequest
	logic [31:0] rdata_reg; // Read data

	// Field views
	wire [1:0] clk_sel = ctrl_one_reg[RRX_CCK_LSB +: 2];
	wire pol_sel = ctrl_one_reg[RRX_POL_BIT];
	wire [1:0] src_sel = ctrl_one_reg[RRX_SRC_LSB +: 2];
	wire [2:0] noise_sel = ctrl_one_reg[RRX_NOISE_LSB +: 3];
	wire [3:0] threshold = ctrl_two_reg[RRX_THR_LSB +: 4];
	wire run = ctrl_two_reg[RRX_RUN_BIT];
	wire [1:0] mode_sel = ctrl_two_reg[RRX_MODE_LSB +: 2];

	// Bus decode
	wire req = AVS_READ_I | AVS_WRITE_I;
	wire [11:0] idx = AVS_ADDRESS_I[RRX_ADDR_W-1:2];
	wire take = req & ~wait_reg; // Edge where master sees waitrequest low
	wire wr_one = take & AVS_WRITE_I & (idx == RRX_IDX_CTRL_ONE);
	wire wr_two = take & AVS_WRITE_I & (idx == RRX_IDX_CTRL_TWO);
	wire run_set = wr_two & AVS_WRITEDATA_I[RRX_RUN_BIT];

	// Input path
	wire raw_level = sync2_reg ^ pol_sel;
	wire [RRX_NOISE_W-1:0] win = noise_len(noise_sel);
	wire filt_bypass = (win == '0);
	wire filt_flip = filt_bypass ? (raw_level != filt_reg) : ((raw_level != filt_reg) & (noise_cnt_reg == win - 15'h0001));
	wire rise = filt_reg & ~filt_prev_reg;
	wire fall = ~filt_reg & filt_prev_reg;

	// Event selection
	wire byte_mode = (src_sel == RRX_SRC_BYTE);
	wire src_edge = (src_sel == RRX_SRC_RISE) ? rise : (src_sel == RRX_SRC_FALL) ? fall : (rise | fall);
	wire mode_used = (src_sel != RRX_SRC_BOTH);
	wire gate_ok = ~mode_used | (mode_sel == RRX_MODE_HIGH ? filt_reg : (mode_sel == RRX_MODE_LOW ? ~filt_reg : 1'b1));
	wire counting = run & ~ovf_reg;
	wire count_step = counting & tick_reg & gate_ok;
	wire overflow = count_step & (count_reg == RRX_CNT_FULL);
	wire decision = (count_reg[7:4] >= threshold);
	wire bit_edge = byte_mode & rise;
	wire meas_edge = ~byte_mode & src_edge;
	wire byte_end = bit_edge & ((byte_done_reg ? RRX_BCNT_FIRST : bcnt_reg + 4'h1) == RRX_BITS_PER_BYTE);

	// Status and read mux
	wire [7:0] status = {bcnt_reg, 1'b0, ovf_reg, next_bit_reg, filt_reg};
	wire [7:0] rd_byte = (idx == RRX_IDX_CTRL_ONE) ? ctrl_one_reg :
		(idx == RRX_IDX_CTRL_TWO) ? ctrl_two_reg :
		(idx == RRX_IDX_CAPTURE) ? capture_reg :
		(idx == RRX_IDX_BUFFER) ? buffer_reg :
		(idx == RRX_IDX_STATUS) ? status : 8'h00; // Unmapped reads zero

	// Avalon slave: one wait state, data loaded with the release
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end
		else if (CLOCK_EN_I)
		begin
			wait_reg <= ~(req & wait_reg);
			// Only reads reload the data, so it stands until the next read
			if (AVS_READ_I & wait_reg)
				rdata_reg <= {24'h00_0000, rd_byte};
		end
	end

	// Control registers; read-only registers ignore writes
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			ctrl_one_reg <= RRX_CTRL_RESET;
			ctrl_two_reg <= RRX_CTRL_RESET;
		end
		else if (CLOCK_EN_I)
		begin
			if (wr_one)
				ctrl_one_reg <= AVS_WRITEDATA_I[7:0];
			if (wr_two)
				ctrl_two_reg <= AVS_WRITEDATA_I[7:0];
		end
	end

	// Prescaler kept in the fc domain as an enable
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			pre_reg <= '0;
			tick_reg <= 1'b0;
		end
		else if (CLOCK_EN_I)
		begin
			pre_reg <= pre_reg + 12'h001;
			tick_reg <= ((pre_reg & pre_mask(clk_sel)) == pre_mask(clk_sel));
		end
	end

	// Synchroniser; the first stage feeds only the second
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end
		else if (CLOCK_EN_I)
		begin
			sync1_reg <= REMOTE_SIGNAL_INPUT_I;
			sync2_reg <= sync1_reg;
		end
	end

	// Noise canceler: level must disagree for a whole window
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			noise_cnt_reg <= '0;
			filt_reg <= 1'b0;
			filt_prev_reg <= 1'b0;
		end
		else if (CLOCK_EN_I)
		begin
			filt_prev_reg <= filt_reg;
			// A short glitch resets the run, so it never reaches the output
			if (filt_flip || raw_level == filt_reg)
				noise_cnt_reg <= '0;
			else
				noise_cnt_reg <= noise_cnt_reg + 15'h0001;
			if (filt_flip)
				filt_reg <= ~filt_reg;
		end
	end

	// Up-counter, capture and overflow
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			count_reg <= 8'h00;
			capture_reg <= RRX_DATA_RESET;
			ovf_reg <= 1'b0;
		end
		else if (CLOCK_EN_I)
		begin
			// Stop clears the counter outright
			if (!run)
				count_reg <= 8'h00;
			else if ((meas_edge || bit_edge) && counting)
			begin
				capture_reg <= count_reg;
				count_reg <= 8'h00;
			end
			else if (overflow)
				count_reg <= 8'h00;
			else if (count_step)
				count_reg <= count_reg + 8'h01;
			// Set wins over the clear by a run write
			if (overflow)
				ovf_reg <= 1'b1;
			else if (run_set)
				ovf_reg <= 1'b0;
		end
	end

	// Bit decisions into the buffer and bit counter
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			buffer_reg <= RRX_DATA_RESET;
			bcnt_reg <= 4'h0;
			byte_done_reg <= 1'b0;
			next_bit_reg <= 1'b0;
		end
		else if (CLOCK_EN_I)
		begin
			next_bit_reg <= decision;
			if (bit_edge)
			begin
				buffer_reg <= {buffer_reg[6:0], decision};
				// First edge after a byte restarts the count at one
				bcnt_reg <= byte_done_reg ? RRX_BCNT_FIRST : bcnt_reg + 4'h1;
				byte_done_reg <= byte_end;
			end
		end
	end

	// Interrupt high the cycle after any event; events in the same cycle give one pulse
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			irq_reg <= 1'b0;
		else if (CLOCK_EN_I)
			irq_reg <= meas_edge | byte_end | overflow;
	end

	assign AVS_READDATA_O = rdata_reg;
	assign AVS_WAITREQUEST_O = wait_reg;
	assign EXT_INTERRUPT_THREE_O = irq_reg;
endmodule : rrx_decoder
`default_nettype wire

// [verification/rrx_decoder_props.sv]
// Port-level assertion checker for the remote decoder
`timescale 1ns/100ps
`default_nettype none
module rrx_decoder_props
	import rrx_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RESET_N_I,
	input wire logic CLOCK_EN_I,
	input wire logic [rrx_pkg::RRX_ADDR_W-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic REMOTE_SIGNAL_INPUT_I,
	input wire logic EXT_INTERRUPT_THREE_O
);
	wire logic [11:0] idx = AVS_ADDRESS_I[13:2]; // Register index
	wire logic ack = !AVS_WAITREQUEST_O; // Answer cycle
	wire logic req = AVS_READ_I || AVS_WRITE_I; // Any request
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);
	// One wait state, then answer
	property p_ack; req && !ack && CLOCK_EN_I |=> ack; endproperty
	a_ack: assert property (p_ack) else $error("request not answered after one wait");
	// No answer without a request
	property p_idle; !req |=> !ack; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	// Answer lasts a single cycle
	property p_one; ack |=> !ack; endproperty
	a_one: assert property (p_one) else $error("waitrequest low too long");
	// Registers are eight bits wide
	property p_hi; ack |-> AVS_READDATA_O[31:8] == 24'h000000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits not zero");
	// Interrupt is a one-cycle pulse
	property p_irq; EXT_INTERRUPT_THREE_O |=> !EXT_INTERRUPT_THREE_O; endproperty
	a_irq: assert property (p_irq) else $error("interrupt longer than one cycle");
	// Unmapped reads return zero
	property p_unm; ack && AVS_READ_I && (idx < RRX_IDX_CTRL_ONE || idx > RRX_IDX_STATUS) |-> AVS_READDATA_O == 0;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	// Status pad bit stays zero
	property p_pad; ack && AVS_READ_I && idx == RRX_IDX_STATUS |-> !AVS_READDATA_O[3]; endproperty
	a_pad: assert property (p_pad) else $error("status pad bit set");
	// Read data hold between reads
	property p_hold; !AVS_READ_I |=> $stable(AVS_READDATA_O); endproperty
	a_hold: assert property (p_hold) else $error("read data changed without read");
endmodule : rrx_decoder_props
bind rrx_decoder rrx_decoder_props i_rrx_decoder_props (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
	.CLOCK_EN_I(CLOCK_EN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.REMOTE_SIGNAL_INPUT_I(REMOTE_SIGNAL_INPUT_I), .EXT_INTERRUPT_THREE_O(EXT_INTERRUPT_THREE_O));
`default_nettype wire

// [verification/rrx_remote_model.sv]
// Partner model: demodulated remote receiver output
`timescale 1ns/100ps
`default_nettype none
module rrx_remote_model (
	input wire logic clk_i,
	output logic sig_o
);
	initial sig_o = 1'b0;
	// Level changes only on edges, whole cycles; bench keeps settings still meanwhile
	task automatic hold(input logic lvl, input int n);
		@(posedge clk_i);
		sig_o <= lvl;
		repeat (n - 1) @(posedge clk_i);
	endtask : hold
endmodule : rrx_remote_model
`default_nettype wire

// [verification/rrx_decoder_tb.sv]
// Self-checking testbench for the remote decoder
`timescale 1ns/100ps
`default_nettype none
module rrx_decoder_tb;
	import rrx_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, irq, wait_o, sig;
	logic [13:0] addr = 14'h0000;
	logic [31:0] wdat = 32'h00000000, rdat, q;
	int fail_count = 0, n_tests = 0, irq_n = 0, cyc = 0, base;
	always #4 clk = ~clk;
	rrx_decoder #(.NOISE_CNT_6(15'h0040), .NOISE_CNT_7(15'h0080)) i_rrx_decoder (.CLOCK_I(clk), .RESET_N_I(rst_n),
		.CLOCK_EN_I(1'b1), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_o), .REMOTE_SIGNAL_INPUT_I(sig), .EXT_INTERRUPT_THREE_O(irq));
	rrx_remote_model i_rrx_remote_model (.clk_i(clk), .sig_o(sig));
	// Interrupt pulse count and hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (irq === 1'b1)
			irq_n <= irq_n + 1;
		if (cyc == 80000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Avalon access held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [11:0] ix, input logic [7:0] d);
		@(posedge clk);
		addr <= {ix, 2'b00};
		rd <= !w;
		wr <= w;
		wdat <= {24'h000000, d};
		// No local cap: only the global cycle guard ends a hung wait
		do
			@(posedge clk);
		while (wait_o !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rchk(input string nm, input logic [11:0] ix, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, ix, 8'h00);
		chk(nm, q & {24'h000000, m}, {24'h000000, e});
	endtask : rchk
	task automatic t_reset();
		// Threshold zero and count zero make the next-bit monitor read one
		for (int i = 0; i < 6; i++)
		begin
			rchk("reset value", RRX_IDX_CTRL_ONE + 12'(i), 8'hFF, (i == 4) ? 8'h02 : 8'h00);
		end
		bus(1'b1, RRX_IDX_CAPTURE, 8'hA5);
		bus(1'b1, RRX_IDX_BUFFER, 8'h5A);
		rchk("capture ro", RRX_IDX_CAPTURE, 8'hFF, 8'h00);
		rchk("buffer ro", RRX_IDX_BUFFER, 8'hFF, 8'h00);
	endtask : t_reset
	task automatic t_ctrl();
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'hE6);
		rchk("ctrl one", RRX_IDX_CTRL_ONE, 8'hFF, 8'hE6);
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'hF7);
		rchk("ctrl two", RRX_IDX_CTRL_TWO, 8'hFF, 8'hF7);
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'h00);
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h00);
	endtask : t_ctrl
	task automatic t_pol();
		i_rrx_remote_model.hold(1'b1, 8);
		rchk("filtered high", RRX_IDX_STATUS, 8'h01, 8'h01);
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h20);
		rchk("inverted level", RRX_IDX_STATUS, 8'h01, 8'h00);
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h00);
		i_rrx_remote_model.hold(1'b0, 8);
	endtask : t_pol
	// Noise code 6 with a 64-cycle window: a 30-cycle glitch dies, a 100-cycle pulse passes
	task automatic t_noise();
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h06);
		base = irq_n;
		i_rrx_remote_model.hold(1'b1, 30);
		rchk("glitch dropped", RRX_IDX_STATUS, 8'h01, 8'h00);
		i_rrx_remote_model.hold(1'b0, 70);
		i_rrx_remote_model.hold(1'b1, 100);
		rchk("pulse passed", RRX_IDX_STATUS, 8'h01, 8'h01);
		i_rrx_remote_model.hold(1'b0, 100);
		chk("noise irqs", 32'(irq_n - base), 32'h1);
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h00);
	endtask : t_noise
	task automatic t_edges();
		for (int s = 0; s < 3; s++)
		begin
			bus(1'b1, RRX_IDX_CTRL_ONE, 8'(s << 3));
			bus(1'b1, RRX_IDX_CTRL_TWO, 8'h03);
			base = irq_n;
			i_rrx_remote_model.hold(1'b1, 20);
			i_rrx_remote_model.hold(1'b0, 25);
			chk("edge irqs", 32'(irq_n - base), (s == 2) ? 32'h2 : 32'h1);
		end
	endtask : t_edges
	// About five counter clocks per low pulse, for every clock select code
	task automatic t_measure();
		for (int k = 0; k < 4; k++)
		begin
			bus(1'b1, RRX_IDX_CTRL_TWO, 8'h00);
			bus(1'b1, RRX_IDX_CTRL_ONE, 8'(k << 6));
			bus(1'b1, RRX_IDX_CTRL_TWO, 8'h08);
			i_rrx_remote_model.hold(1'b0, 320 << (2 * k));
			i_rrx_remote_model.hold(1'b1, 10);
			bus(1'b0, RRX_IDX_CAPTURE, 8'h00);
			chk("capture near five", 32'(q >= 4 && q <= 6), 32'h1);
			i_rrx_remote_model.hold(1'b0, 10);
		end
		// Falling-edge source, count only while low: a high pulse adds almost nothing
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'h00);
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h08);
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'h0B);
		i_rrx_remote_model.hold(1'b1, 320);
		i_rrx_remote_model.hold(1'b0, 10);
		bus(1'b0, RRX_IDX_CAPTURE, 8'h00);
		chk("gated count", 32'(q <= 1), 32'h1);
		// Both-edge source ignores the same mode, so the high pulse is counted
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h10);
		i_rrx_remote_model.hold(1'b1, 320);
		i_rrx_remote_model.hold(1'b0, 10);
		bus(1'b0, RRX_IDX_CAPTURE, 8'h00);
		chk("mode ignored", 32'(q >= 4 && q <= 6), 32'h1);
	endtask : t_measure
	task automatic t_ovf();
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'h00);
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h00);
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'h08);
		base = irq_n;
		i_rrx_remote_model.hold(1'b0, 16600);
		rchk("overflow set", RRX_IDX_STATUS, 8'h04, 8'h04);
		chk("overflow irq", 32'(irq_n - base), 32'h1);
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'h08);
		rchk("overflow cleared", RRX_IDX_STATUS, 8'h04, 8'h00);
	endtask : t_ovf
	task automatic t_byte();
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'h00);
		bus(1'b1, RRX_IDX_CTRL_ONE, 8'h18);
		bus(1'b1, RRX_IDX_CTRL_TWO, 8'h18);
		base = irq_n;
		for (int i = 7; i >= 0; i--)
		begin
			i_rrx_remote_model.hold(1'b0, (8'hB2 >> i) & 1 ? 1600 : 400);
			i_rrx_remote_model.hold(1'b1, 100);
		end
		rchk("byte", RRX_IDX_BUFFER, 8'hFF, 8'hB2);
		chk("byte irq", 32'(irq_n - base), 32'h1);
		rchk("bit count", RRX_IDX_STATUS, 8'hF0, 8'h80);
		i_rrx_remote_model.hold(1'b0, 400);
		i_rrx_remote_model.hold(1'b1, 100);
		rchk("bit count restart", RRX_IDX_STATUS, 8'hF0, 8'h10);
	endtask : t_byte
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_ctrl();
		t_pol();
		t_noise();
		t_edges();
		t_measure();
		t_ovf();
		t_byte();
		tally_and_finish();
	end
endmodule : rrx_decoder_tb
`default_nettype wire
